// ===== flr_map.svh
// Offsets and counts of the fault log readout image
`ifndef FLR_MAP_SVH
`define FLR_MAP_SVH
`define FLR_LOOP_BYTES 8'h2e
`define FLR_LOOP_TOP 6'h2d
`define FLR_LAST_LOOP_START 8'hde
`define FLR_INVALID_FIRST 8'he8
`define FLR_INVALID_LAST 8'hed
`define FLR_RSVD_FIRST 8'hee
`define FLR_RSVD_LAST 8'hfe
`define FLR_RSVD_VALUE 8'h00
`define FLR_IMAGE_BYTES 8'hff
`define FLR_TEMP_IDX 6'h19
`define FLR_VIN_IDX 6'h0c
`define FLR_CHAN_HI_TOP 6'h2d
`define FLR_CHAN_LO_TOP 6'h16
`endif

// ===== flr_pkg.sv
// Types for the fault log readout image streamer
`timescale 1ns/1ps
package flr_pkg;
   typedef struct packed {
      logic [7:0] mfr_ext;
      logic [7:0] mfr;
      logic [7:0] vout_status;
      logic [15:0] vout;
   } flr_chan_t;
   typedef struct packed {
      logic [7:0] temp_status;
      logic [15:0] temp;
      logic [7:0] vin_status;
      logic [15:0] vin;
   } flr_misc_t;
   typedef struct packed {
      logic valid;
      logic last;
      logic invalid;
      logic [7:0] offset;
      logic [7:0] data;
   } flr_byte_t;
   typedef enum logic [1:0] {FLR_IDLE, FLR_SEND} flr_state_t;
endpackage

// ===== flr_readout.sv
// Streams the tail of the fault log image, one byte per request, offsets 0x00 to 0xFE
// Function
// - Telemetry is laid out as 46-byte loops, index 45 down to 0, channels 7 to 0 with temp and vin records between.
// - Bytes 0xE8 to 0xED of the truncated last loop are flagged invalid.
// - Reserved bytes 0xEE to 0xFE read as 0x00.
// - One block read returns all 255 bytes, 0x00 to 0xFE, in increasing order.
`timescale 1ns/1ps
`default_nettype none
`include "flr_map.svh"
module flr_readout (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Log content, held stable by the logger during a read
   input wire flr_pkg::flr_chan_t [7:0] chan_in,
   input wire flr_pkg::flr_misc_t misc_in,
   // Block read control, same clock domain
   input wire logic start_in,
   input wire logic next_in,
   // Byte stream
   output flr_pkg::flr_byte_t byte_out,
   output logic busy_out
);
   logic rst_meta;
   logic rst_sync_n;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   flr_pkg::flr_state_t state;
   flr_pkg::flr_state_t next_state;
   logic [7:0] offset;
   logic [7:0] next_offset;
   flr_pkg::flr_byte_t next_byte;
   logic next_busy;

   // Byte content for a loop index; channel groups of five bytes
   function automatic logic [7:0] flr_loop_byte(input logic [5:0] idx,
         input flr_pkg::flr_chan_t [7:0] ch, input flr_pkg::flr_misc_t m);
      logic [5:0] rel;
      logic [2:0] chn;
      logic [2:0] pos;
      flr_pkg::flr_chan_t c;
      rel = 6'h00;
      chn = 3'h0;
      pos = 3'h0;
      c = ch[0];
      if (idx == `FLR_TEMP_IDX) begin
         return m.temp_status;
      end
      if (idx == `FLR_TEMP_IDX - 6'h01) begin
         return m.temp[15:8];
      end
      if (idx == `FLR_TEMP_IDX - 6'h02) begin
         return m.temp[7:0];
      end
      if (idx == `FLR_VIN_IDX) begin
         return m.vin_status;
      end
      if (idx == `FLR_VIN_IDX - 6'h01) begin
         return m.vin[15:8];
      end
      if (idx == `FLR_VIN_IDX - 6'h02) begin
         return m.vin[7:0];
      end
      if (idx > `FLR_TEMP_IDX) begin
         rel = `FLR_CHAN_HI_TOP - idx;
         chn = 3'h7 - 3'(rel / 6'h05);
      end else if (idx > `FLR_VIN_IDX) begin
         rel = `FLR_CHAN_LO_TOP - idx;
         chn = 3'h3 - 3'(rel / 6'h05);
      end else begin
         rel = (`FLR_VIN_IDX - 6'h03) - idx;
         chn = 3'h1 - 3'(rel / 6'h05);
      end
      pos = 3'(rel % 6'h05);
      c = ch[chn];
      unique case (pos)
         3'h0: return c.mfr_ext;
         3'h1: return c.mfr;
         3'h2: return c.vout_status;
         3'h3: return c.vout[15:8];
         3'h4: return c.vout[7:0];
         default: return 8'h00;
      endcase
   endfunction

   // Image byte for an offset below the reserved area, loops repeat every 46 bytes
   function automatic logic [7:0] flr_image_byte(input logic [7:0] off,
         input flr_pkg::flr_chan_t [7:0] ch, input flr_pkg::flr_misc_t m);
      logic [7:0] into;
      into = 8'h00;
      if (off >= `FLR_RSVD_FIRST) begin
         return `FLR_RSVD_VALUE;
      end
      // Header area before the loops is outside this block and reads zero
      if (off < `FLR_LAST_LOOP_START - 8'd3 * `FLR_LOOP_BYTES) begin
         return 8'h00;
      end
      into = 8'((off - (`FLR_LAST_LOOP_START - 8'd3 * `FLR_LOOP_BYTES)) % `FLR_LOOP_BYTES);
      return flr_loop_byte(`FLR_LOOP_TOP - into[5:0], ch, m);
   endfunction

   always_comb begin
      next_state = state;
      next_offset = offset;
      next_busy = busy_out;
      next_byte = byte_out;
      next_byte.valid = 1'b0;
      unique case (state)
         flr_pkg::FLR_IDLE: begin
            if (start_in) begin
               next_state = flr_pkg::FLR_SEND;
               next_offset = 8'h00;
               next_busy = 1'b1;
            end
         end
         flr_pkg::FLR_SEND: begin
            // The read ends only after 0xFE; the reserved tail is always sent
            if (next_in) begin
               next_byte.valid = 1'b1;
               next_byte.offset = offset;
               next_byte.data = flr_image_byte(offset, chan_in, misc_in);
               next_byte.invalid = (offset >= `FLR_INVALID_FIRST) &&
                     (offset <= `FLR_INVALID_LAST);
               next_byte.last = (offset == `FLR_RSVD_LAST);
               if (offset == `FLR_IMAGE_BYTES - 8'h01) begin
                  next_state = flr_pkg::FLR_IDLE;
                  next_busy = 1'b0;
               end else begin
                  next_offset = offset + 8'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= flr_pkg::FLR_IDLE;
         offset <= 8'h00;
         busy_out <= 1'b0;
         byte_out <= '0;
      end else begin
         state <= next_state;
         offset <= next_offset;
         busy_out <= next_busy;
         byte_out <= next_byte;
      end
   end
endmodule
`default_nettype wire

// ===== flr_readout_asserts.sv
// Checker for the log image byte stream
`timescale 1ns/1ps
`default_nettype none
module flr_readout_chk (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire flr_pkg::flr_chan_t [7:0] chan_in,
   input wire flr_pkg::flr_misc_t misc_in,
   input wire logic start_in,
   input wire logic next_in,
   input wire flr_pkg::flr_byte_t byte_out,
   input wire logic busy_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic v;
   logic [7:0] o;
   logic [7:0] prev;
   assign v = byte_out.valid;
   assign o = byte_out.offset;
   always_ff @(posedge clk_in) if (v) prev <= o;
   sequence take_s; start_in && !busy_out; endsequence
   start_busy_a: assert property (take_s |=> busy_out) else $error("no busy");
   byte_reply_a: assert property (busy_out && next_in |=> v) else $error("no byte");
   offset_step_a: assert property (v && o != 8'h00 |-> o == prev + 8'h01) else $error("skip");
   invalid_flag_a: assert property (v |-> byte_out.invalid == (o inside {[8'he8:8'hed]}))
      else $error("flag");
   reserved_zero_a: assert property (v && o >= 8'hee |-> byte_out.data == 8'h00)
      else $error("reserved");
   loop_order_a: assert property (v && o == 8'hde |-> byte_out.data == chan_in[7].mfr_ext)
      else $error("order");
   read_end_a: assert property (v && byte_out.last |-> o == 8'hfe && !busy_out)
      else $error("end");
endmodule
`default_nettype wire

// ===== flr_host_model.sv
// Host that clocks out the whole log image
`timescale 1ns/1ps
`default_nettype none
module flr_host_model (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic stall_in,
   input wire logic busy_in,
   output logic start_out,
   output logic next_out
);
   logic [8:0] sent;
   logic [8:0] cnt;
   assign cnt = sent + {8'h00, next_out && busy_in};
   always @(posedge clk_in) begin
      start_out <= go_in && !busy_in;
      sent <= start_out ? 9'h000 : cnt;
      next_out <= busy_in && !stall_in && cnt < 9'h0ff;
   end
endmodule
`default_nettype wire

// ===== test_flr_readout.sv
// Testbench for the log image streamer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module test_flr_readout;
   logic clk_in = 0, rst_n_in = 0, go = 0, stall = 0, start_in, next_in, busy_out;
   flr_pkg::flr_chan_t [7:0] chan_in = '0;
   flr_pkg::flr_misc_t misc_in = '0;
   flr_pkg::flr_byte_t byte_out;
   logic [31:0] lf = 32'hf43401b4;
   int check_count = 0, bad_count = 0, got = 0;
   flr_readout dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .chan_in(chan_in),
      .misc_in(misc_in), .start_in(start_in), .next_in(next_in), .byte_out(byte_out),
      .busy_out(busy_out));
   flr_host_model host_u (.clk_in(clk_in), .go_in(go), .stall_in(stall), .busy_in(busy_out),
      .start_out(start_in), .next_out(next_in));
   initial forever #25 clk_in = ~clk_in;
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] want(input logic [7:0] o);
      int i, j;
      if (o < 8'h54 || o > 8'hed) return 8'h00;
      i = 45 - (o - 8'h54) % 46;
      if (i inside {[23:25]}) return misc_in[47 - 8 * (25 - i) -: 8];
      if (i inside {[10:12]}) return misc_in[23 - 8 * (12 - i) -: 8];
      j = i > 25 ? 45 - i : i > 12 ? 22 - i : 9 - i;
      return chan_in[(i > 25 ? 7 : i > 12 ? 3 : 1) - j / 5][39 - 8 * (j % 5) -: 8];
   endfunction
   always @(posedge clk_in) if (byte_out.valid === 1'b1) begin
      `CHK(byte_out.offset, got[7:0])
      `CHK(byte_out.data, want(got[7:0]))
      `CHK(byte_out.invalid, got inside {[232:237]})
      `CHK(byte_out.last, got == 254)
      got++;
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Random stalls make the host hold off between requests
   task automatic read_image(input logic s);
      int n;
      got = 0;
      go <= 1;
      @(posedge clk_in);
      go <= 0;
      for (n = 0; n < 2000 && (n < 4 || busy_out === 1'b1); n++) begin
         @(posedge clk_in);
         lf = step(lf);
         stall <= s & lf[0];
         @(negedge clk_in);
      end
      if (n == 2000) begin
         bad_count++;
         end_of_test;
      end
      repeat (2) @(posedge clk_in);
      `CHK(got, 255)
      `CHK(busy_out, 1'b0)
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1;
      repeat (4) @(posedge clk_in);
      for (int r = 0; r < 4; r++) begin
         for (int k = 0; k < 8; k++) begin
            lf = step(lf);
            chan_in[k] <= r == 1 ? '1 : {lf[7:0], lf};
         end
         misc_in <= r == 1 ? '1 : {lf[15:0], step(lf)};
         read_image(r > 1);
      end
      end_of_test;
   end
endmodule
bind flr_readout flr_readout_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .chan_in(chan_in), .misc_in(misc_in), .start_in(start_in), .next_in(next_in),
   .byte_out(byte_out), .busy_out(busy_out));
`default_nettype wire
